// [include/cbs_pkg.sv]
// Constants, types and opcode decode for the bus-cycle sequencer
package cbs_pkg;

  // Fixed bus addresses and reset values
  localparam logic [15:0] CBS_DUMMY_ADDR = 16'hffff;
  localparam logic [15:0] CBS_RESET_PC   = 16'h0000;

  // Opcodes with a documented value
  localparam logic [7:0] CBS_OP_PAGE  = 8'h1a;
  localparam logic [7:0] CBS_OP_JUMP_X  = 8'h6e;
  localparam logic [7:0] CBS_OP_TEST_X  = 8'h6d;
  localparam logic [7:0] CBS_OP_CALL_E  = 8'hbd;
  localparam logic [7:0] CBS_OP_LOAD_Y  = 8'hee;
  localparam logic [7:0] CBS_OP_STORE_Y = 8'hef;
  // Second bytes of the paged extended compares
  localparam logic [7:0] CBS_OP_CMPD_E  = 8'hb3;
  localparam logic [7:0] CBS_OP_CMPY_E  = 8'hbc;

  // Opcode field layout: high nibble selects the group
  localparam logic [3:0] CBS_HI_RMW_X = 4'h6;
  localparam logic [3:0] CBS_HI_A8_X  = 4'ha;
  localparam logic [3:0] CBS_HI_B8_X  = 4'he;
  localparam logic [3:0] CBS_HI_EXT   = 4'hb;
  localparam logic [3:0] CBS_LO_ST8   = 4'h7;
  localparam logic [3:0] CBS_LO_AR16  = 4'h3;
  localparam logic [3:0] CBS_LO_CMPX  = 4'hc;
  localparam logic [3:0] CBS_LO_LD16  = 4'he;
  localparam logic [3:0] CBS_LO_STB16 = 4'hd;
  localparam logic [3:0] CBS_LO_ST16  = 4'hf;
  localparam logic [3:0] CBS_LO_CALL_X = 4'hd;

  typedef enum logic [3:0] {
    CBS_S_OP     = 4'b0000,
    CBS_S_OP2    = 4'b0001,
    CBS_S_OFF    = 4'b0010,
    CBS_S_AH     = 4'b0011,
    CBS_S_AL     = 4'b0100,
    CBS_S_DUM    = 4'b0101,
    CBS_S_RD_H   = 4'b0110,
    CBS_S_RD_L   = 4'b0111,
    CBS_S_DUM2   = 4'b1000,
    CBS_S_DUM3   = 4'b1001,
    CBS_S_WR_H   = 4'b1010,
    CBS_S_WR_L   = 4'b1011,
    CBS_S_SUB    = 4'b1100,
    CBS_S_PUSH_L = 4'b1101,
    CBS_S_PUSH_H = 4'b1110
  } cbs_state_t;

  typedef enum logic [3:0] {
    CBS_C_NONE   = 4'b0000,
    CBS_C_JUMP_X = 4'b0001,
    CBS_C_RD8_X  = 4'b0010,
    CBS_C_ST8_X  = 4'b0011,
    CBS_C_LD16_X = 4'b0100,
    CBS_C_ST16_X = 4'b0101,
    CBS_C_AR16_X = 4'b0110,
    CBS_C_RMW_X  = 4'b0111,
    CBS_C_TEST_X = 4'b1000,
    CBS_C_CALL_E = 4'b1001,
    CBS_C_CMP_E  = 4'b1010,
    CBS_C_RD8_E  = 4'b1011
  } cbs_class_t;

  // Single-byte opcode to cycle class
  function automatic cbs_class_t cbs_decode(input logic [7:0] op);
    cbs_class_t c;
    c = CBS_C_NONE;
    if (op == CBS_OP_JUMP_X) begin
      c = CBS_C_JUMP_X;
    end else if (op == CBS_OP_TEST_X) begin
      c = CBS_C_TEST_X;
    end else if (op == CBS_OP_CALL_E) begin
      c = CBS_C_CALL_E;
    end else if (op[7:4] == CBS_HI_RMW_X) begin
      c = CBS_C_RMW_X;
    end else if (op[7:4] == CBS_HI_EXT) begin
      c = CBS_C_RD8_E;
    end else if (op[7:4] == CBS_HI_A8_X || op[7:4] == CBS_HI_B8_X) begin
      if (op[3:0] == CBS_LO_ST8) begin
        c = CBS_C_ST8_X;
      end else if (op[3:0] == CBS_LO_AR16) begin
        c = CBS_C_AR16_X;
      end else if (op[3:0] == CBS_LO_ST16) begin
        c = CBS_C_ST16_X;
      end else if (op[3:0] == CBS_LO_LD16) begin
        c = CBS_C_LD16_X;
      end else if (op[3:0] == CBS_LO_CMPX) begin
        c = (op[7:4] == CBS_HI_A8_X) ? CBS_C_AR16_X : CBS_C_LD16_X;
      end else if (op[3:0] == CBS_LO_STB16) begin
        // Indexed call shares this slot and is not sequenced here
        c = (op[7:4] == CBS_HI_B8_X) ? CBS_C_ST16_X : CBS_C_NONE;
      end else begin
        c = CBS_C_RD8_X;
      end
    end
    return c;
  endfunction

  // Second byte after the page prefix to cycle class
  function automatic cbs_class_t cbs_decode2(input logic [7:0] op);
    cbs_class_t c;
    c = CBS_C_NONE;
    if (op == CBS_OP_LOAD_Y) begin
      c = CBS_C_LD16_X;
    end else if (op == CBS_OP_STORE_Y) begin
      c = CBS_C_ST16_X;
    end else if (op == CBS_OP_CMPD_E || op == CBS_OP_CMPY_E) begin
      c = CBS_C_CMP_E;
    end
    return c;
  endfunction

  // All sequencer state
  typedef struct packed {
    cbs_state_t  state;
    cbs_class_t  cls;
    logic [15:0] pc;
    logic [15:0] ea;
    logic [7:0]  op;
    logic [15:0] rd;
    logic        done;
  } cbs_regs_t;

  localparam cbs_regs_t CBS_REGS_RESET = '{
    state: CBS_S_OP, cls: CBS_C_NONE, pc: CBS_RESET_PC,
    ea: 16'h0000, op: 8'h00, rd: 16'h0000, done: 1'b0};

endpackage

// [include/cbs_bus_if.sv]
// Carrier between the sequencer core and its bus-cycle driver
`timescale 1ns/1ps
interface cbs_bus_if;
  cbs_pkg::cbs_state_t state;
  cbs_pkg::cbs_class_t cls;
  logic [15:0]         pc;
  logic [15:0]         ea;
  logic [15:0]         sp;
  logic [15:0]         wdata;
  logic [15:0]         addr;
  logic                read;
  logic [7:0]          dout;

  modport seq (output state, output cls, output pc, output ea,
               output sp, output wdata,
               input addr, input read, input dout);
  modport drv (input state, input cls, input pc, input ea,
               input sp, input wdata,
               output addr, output read, output dout);
endinterface

// [src/cbs_bus_drv.sv]
// Address, read/write and write-data selection per bus cycle
`timescale 1ns/1ps
module cbs_bus_drv (
  cbs_bus_if.drv bus
);
  logic hi16;

  // Classes whose operand is two bytes wide
  assign hi16 = bus.cls == cbs_pkg::CBS_C_LD16_X ||
                bus.cls == cbs_pkg::CBS_C_ST16_X ||
                bus.cls == cbs_pkg::CBS_C_AR16_X ||
                bus.cls == cbs_pkg::CBS_C_CMP_E;

  always_comb begin
    bus.addr = bus.pc;
    bus.read = 1'b1;
    bus.dout = 8'h00;
    case (bus.state)
      cbs_pkg::CBS_S_DUM,
      cbs_pkg::CBS_S_DUM2,
      cbs_pkg::CBS_S_DUM3: begin
        bus.addr = cbs_pkg::CBS_DUMMY_ADDR;
      end
      cbs_pkg::CBS_S_RD_H: begin
        bus.addr = bus.ea;
      end
      cbs_pkg::CBS_S_RD_L: begin
        bus.addr = bus.ea + {15'h0000, hi16};
      end
      cbs_pkg::CBS_S_WR_H: begin
        bus.addr = bus.ea;
        bus.read = 1'b0;
        bus.dout = bus.wdata[15:8];
      end
      cbs_pkg::CBS_S_WR_L: begin
        bus.addr = bus.ea + {15'h0000, hi16};
        bus.read = 1'b0;
        bus.dout = bus.wdata[7:0];
      end
      cbs_pkg::CBS_S_SUB: begin
        bus.addr = bus.ea;
      end
      cbs_pkg::CBS_S_PUSH_L: begin
        bus.addr = bus.sp;
        bus.read = 1'b0;
        bus.dout = bus.pc[7:0];
      end
      cbs_pkg::CBS_S_PUSH_H: begin
        bus.addr = bus.sp - 16'h0001;
        bus.read = 1'b0;
        bus.dout = bus.pc[15:8];
      end
      default: begin
        bus.addr = bus.pc;
      end
    endcase
  end
endmodule

// [src/cbs_seq.sv]
// Bus-cycle sequencer: fetch, address and operand cycles per instruction
// Functional notes
// - Extended compare: opcodes, address pair, two reads, dummy; 7 cycles.
// - Extended call, opcode $BD, 6 cycles; target fetched high byte first.
// - Call cycle 4 reads the subroutine's first opcode at target, read high.
// - Call writes return low byte at stack pointer, high at pointer - 1.
// - Indexed jump $6E: opcode, offset, dummy read at $FFFF; 3 cycles.
// - Indexed: offset, dummy read at $FFFF, operand at index plus offset.
// - Indexed read-modify-write: read, dummy at $FFFF, write back; 6 cycles.
// - Indexed test $6D: read operand, two dummy reads, no write; 6 cycles.
// - Indexed 16-bit loads: high at indexed address, low at next; 5 cycles.
// - Second-index load: $1A, $EE, offset, dummy, two reads; 6 cycles.
// - Second-index store: $1A, $EF; writes high then low in cycles 5, 6.
// - Indexed 16-bit stores: high at indexed address, low next; 5 cycles.
// - Indexed 8-bit store writes in cycle 4; 8-bit reads read in cycle 4.
// - Indexed 16-bit add, subtract, compare: high read cycle 4; 6 cycles.
// - Two-byte opcodes: prefix at opcode address, second byte next.
// - Extended 8-bit read: opcode, address high and low, operand; 4 cycles.
`timescale 1ns/1ps
module cbs_seq #(
  parameter logic [15:0] START_PC = cbs_pkg::CBS_RESET_PC
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // CPU bus; data pin split into in, out and enable
  output logic [15:0]      cpu_addr,
  output logic             cpu_read,
  input  wire logic [7:0]  cpu_data_in,
  output logic [7:0]       cpu_data_out,
  output logic             cpu_data_oe,
  // Register values from the core
  input  wire logic [15:0] first_index_register,
  input  wire logic [15:0] stack_ptr,
  input  wire logic [15:0] store_data,
  // Results to the core
  output logic [15:0]      operand_data,
  output logic [7:0]       opcode,
  output logic             instr_done
);
  cbs_pkg::cbs_regs_t s_reg;
  cbs_pkg::cbs_regs_t s_next;
  cbs_bus_if          bus ();

  cbs_bus_drv cbs_bus_drv_i (
    .bus (bus.drv)
  );

  assign bus.state = s_reg.state;
  assign bus.cls   = s_reg.cls;
  assign bus.pc    = s_reg.pc;
  assign bus.ea    = s_reg.ea;
  assign bus.sp    = stack_ptr;
  assign bus.wdata = store_data;

  assign cpu_addr     = bus.addr;
  assign cpu_read     = bus.read;
  assign cpu_data_out = bus.dout;
  assign cpu_data_oe  = ~bus.read;
  assign operand_data = s_reg.rd;
  assign opcode       = s_reg.op;
  assign instr_done   = s_reg.done;

  // First cycle after the opcode byte, shared by normal fetch and the
  // opcode already read inside a call
  function automatic cbs_pkg::cbs_state_t after_op(
    input cbs_pkg::cbs_class_t c);
    cbs_pkg::cbs_state_t n;
    // Extended classes fetch a two-byte address, indexed ones an offset
    case (c)
      cbs_pkg::CBS_C_CALL_E,
      cbs_pkg::CBS_C_CMP_E,
      cbs_pkg::CBS_C_RD8_E:  n = cbs_pkg::CBS_S_AH;
      cbs_pkg::CBS_C_JUMP_X,
      cbs_pkg::CBS_C_RD8_X,
      cbs_pkg::CBS_C_ST8_X,
      cbs_pkg::CBS_C_LD16_X,
      cbs_pkg::CBS_C_ST16_X,
      cbs_pkg::CBS_C_AR16_X,
      cbs_pkg::CBS_C_RMW_X,
      cbs_pkg::CBS_C_TEST_X: n = cbs_pkg::CBS_S_OFF;
      default:               n = cbs_pkg::CBS_S_OP;
    endcase
    return n;
  endfunction

  always_comb begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    case (s_reg.state)
      cbs_pkg::CBS_S_OP: begin
        s_next.op = cpu_data_in;
        s_next.pc = s_reg.pc + 16'h0001;
        if (cpu_data_in == cbs_pkg::CBS_OP_PAGE) begin
          s_next.state = cbs_pkg::CBS_S_OP2;
        end else begin
          s_next.cls   = cbs_pkg::cbs_decode(cpu_data_in);
          s_next.state = after_op(cbs_pkg::cbs_decode(cpu_data_in));
          // Unknown opcodes are skipped as one-cycle fetches
          s_next.done  = cbs_pkg::cbs_decode(cpu_data_in) ==
                         cbs_pkg::CBS_C_NONE;
        end
      end
      cbs_pkg::CBS_S_OP2: begin
        // Prefix is spent; the second byte alone picks the class
        s_next.op    = cpu_data_in;
        s_next.pc    = s_reg.pc + 16'h0001;
        s_next.cls   = cbs_pkg::cbs_decode2(cpu_data_in);
        s_next.state = after_op(cbs_pkg::cbs_decode2(cpu_data_in));
        s_next.done  = cbs_pkg::cbs_decode2(cpu_data_in) ==
                       cbs_pkg::CBS_C_NONE;
      end
      cbs_pkg::CBS_S_OFF: begin
        // Unsigned offset added to the first index register
        s_next.ea    = first_index_register + {8'h00, cpu_data_in};
        s_next.pc    = s_reg.pc + 16'h0001;
        s_next.state = cbs_pkg::CBS_S_DUM;
      end
      cbs_pkg::CBS_S_AH: begin
        s_next.ea[15:8] = cpu_data_in;
        s_next.pc       = s_reg.pc + 16'h0001;
        s_next.state    = cbs_pkg::CBS_S_AL;
      end
      cbs_pkg::CBS_S_AL: begin
        s_next.ea[7:0] = cpu_data_in;
        s_next.pc      = s_reg.pc + 16'h0001;
        case (s_reg.cls)
          cbs_pkg::CBS_C_CALL_E: s_next.state = cbs_pkg::CBS_S_SUB;
          cbs_pkg::CBS_C_CMP_E: s_next.state = cbs_pkg::CBS_S_RD_H;
          default:              s_next.state = cbs_pkg::CBS_S_RD_L;
        endcase
      end
      cbs_pkg::CBS_S_DUM: begin
        case (s_reg.cls)
          cbs_pkg::CBS_C_JUMP_X: begin
            s_next.pc    = s_reg.ea;
            s_next.done  = 1'b1;
            s_next.state = cbs_pkg::CBS_S_OP;
          end
          cbs_pkg::CBS_C_ST8_X:  s_next.state = cbs_pkg::CBS_S_WR_L;
          cbs_pkg::CBS_C_ST16_X: s_next.state = cbs_pkg::CBS_S_WR_H;
          cbs_pkg::CBS_C_LD16_X,
          cbs_pkg::CBS_C_AR16_X: s_next.state = cbs_pkg::CBS_S_RD_H;
          default:               s_next.state = cbs_pkg::CBS_S_RD_L;
        endcase
      end
      cbs_pkg::CBS_S_RD_H: begin
        s_next.rd[15:8] = cpu_data_in;
        s_next.state    = cbs_pkg::CBS_S_RD_L;
      end
      cbs_pkg::CBS_S_RD_L: begin
        s_next.rd[7:0] = cpu_data_in;
        case (s_reg.cls)
          cbs_pkg::CBS_C_AR16_X,
          cbs_pkg::CBS_C_CMP_E,
          cbs_pkg::CBS_C_RMW_X,
          cbs_pkg::CBS_C_TEST_X: s_next.state = cbs_pkg::CBS_S_DUM2;
          default: begin
            s_next.done  = 1'b1;
            s_next.state = cbs_pkg::CBS_S_OP;
          end
        endcase
      end
      cbs_pkg::CBS_S_DUM2: begin
        case (s_reg.cls)
          cbs_pkg::CBS_C_TEST_X: s_next.state = cbs_pkg::CBS_S_DUM3;
          cbs_pkg::CBS_C_RMW_X:  s_next.state = cbs_pkg::CBS_S_WR_L;
          default: begin
            s_next.done  = 1'b1;
            s_next.state = cbs_pkg::CBS_S_OP;
          end
        endcase
      end
      cbs_pkg::CBS_S_DUM3: begin
        s_next.done  = 1'b1;
        s_next.state = cbs_pkg::CBS_S_OP;
      end
      cbs_pkg::CBS_S_WR_H: begin
        s_next.state = cbs_pkg::CBS_S_WR_L;
      end
      cbs_pkg::CBS_S_WR_L: begin
        s_next.done  = 1'b1;
        s_next.state = cbs_pkg::CBS_S_OP;
      end
      cbs_pkg::CBS_S_SUB: begin
        // Target opcode is already in hand; the push cycles still need
        // the return address, so the program counter moves afterwards
        s_next.op    = cpu_data_in;
        s_next.state = cbs_pkg::CBS_S_PUSH_L;
      end
      cbs_pkg::CBS_S_PUSH_L: begin
        s_next.state = cbs_pkg::CBS_S_PUSH_H;
      end
      cbs_pkg::CBS_S_PUSH_H: begin
        // Opcode read in the target cycle decides the next step
        s_next.done = 1'b1;
        s_next.pc   = s_reg.ea + 16'h0001;
        if (s_reg.op == cbs_pkg::CBS_OP_PAGE) begin
          s_next.state = cbs_pkg::CBS_S_OP2;
        end else begin
          s_next.cls   = cbs_pkg::cbs_decode(s_reg.op);
          s_next.state = after_op(cbs_pkg::cbs_decode(s_reg.op));
        end
      end
      default: begin
        s_next.state = cbs_pkg::CBS_S_OP;
      end
    endcase
  end

  // Start address is a parameter so the boot fetch can be placed anywhere
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_reg <= cbs_pkg::CBS_REGS_RESET;
      s_reg.pc <= START_PC;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule

// [test/cbs_mem_model.sv]
// Program and data memory on the CPU bus side of the sequencer
`timescale 1ns/1ps
module cbs_mem_model (
  // Clock
  input  wire logic        clk_sys,
  // CPU bus
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_read,
  input  wire logic [7:0]  cpu_data_out,
  input  wire logic        cpu_data_oe,
  output wire logic [7:0]  cpu_data_in
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'h00;

  // Address-derived fill: each byte is the XOR of its address's high and low bytes
  initial begin
    for (int a = 0; a < 65536; a++) begin
      mem[a] = a[7:0] ^ a[15:8];
    end
  end

  // Undriven bus shows the inverse of the last byte, not a stale copy
  assign cpu_data_in = cpu_read ? mem[cpu_addr] : ~last_q;

  always @(posedge clk_sys) begin
    if (cpu_data_oe) begin
      mem[cpu_addr] <= cpu_data_out;
    end
    last_q <= cpu_data_in;
  end
endmodule

// [test/cbs_seq_sva.sv]
// Bus-cycle assertions on the sequencer's ports
`timescale 1ns/1ps
module cbs_seq_sva #(
  parameter logic [15:0] START_PC = 16'h0000
) (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  // CPU bus
  input wire logic [15:0] cpu_addr,
  input wire logic        cpu_read,
  input wire logic [7:0]  cpu_data_in,
  input wire logic [7:0]  cpu_data_out,
  input wire logic        cpu_data_oe,
  // Core side
  input wire logic [15:0] first_index_register,
  input wire logic [15:0] stack_ptr,
  input wire logic [15:0] store_data,
  input wire logic [15:0] operand_data,
  input wire logic [7:0]  opcode,
  input wire logic        instr_done
);
  logic first_q;
  logic fetch;
  always_ff @(posedge clk_sys) begin
    first_q <= sys_rst;
  end
  // Opcode cycles: first after reset, or right after an instruction
  assign fetch = instr_done | first_q;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  AST_RESET_FETCH: assert property (
    first_q |-> cpu_addr == START_PC && cpu_read)
    else $error("First fetch not at start address");
  AST_OE_RW: assert property (
    cpu_data_oe == !cpu_read)
    else $error("Data enable disagrees with read line");
  AST_JUMP_X: assert property (
    fetch && cpu_data_in == 8'h6e |=> (cpu_addr == $past(cpu_addr) + 16'h1)
    ##1 (cpu_addr == 16'hffff && cpu_read) ##1 instr_done)
    else $error("Indexed jump cycles wrong");
  AST_TEST_X: assert property (
    fetch && cpu_data_in == 8'h6d |=> ##1 cpu_addr == 16'hffff ##1 cpu_read
    ##1 (cpu_read && cpu_addr == 16'hffff) [*2] ##1 instr_done)
    else $error("Indexed test cycles wrong");
  AST_RMW_X: assert property (
    fetch && cpu_data_in[7:4] == 4'h6 && cpu_data_in != 8'h6d
    && cpu_data_in != 8'h6e |-> ##5 (!cpu_read
    && cpu_addr == $past(cpu_addr, 2) && $past(cpu_addr) == 16'hffff)
    ##1 instr_done)
    else $error("Write-back not at read address");
  AST_CALL_EXT: assert property (
    fetch && cpu_data_in == 8'hbd |-> ##3 (cpu_read
    && cpu_addr == {$past(cpu_data_in, 2), $past(cpu_data_in)})
    ##1 (!cpu_read && cpu_addr == stack_ptr)
    ##1 (!cpu_read && cpu_addr == stack_ptr - 16'h1)
    ##1 (instr_done && cpu_addr == $past(cpu_addr, 3) + 16'h1))
    else $error("Call cycles wrong");
  AST_STORE8_X: assert property (
    fetch && (cpu_data_in == 8'ha7 || cpu_data_in == 8'he7) |-> ##1 cpu_read
    ##1 cpu_addr == 16'hffff ##1 (!cpu_read && cpu_data_oe
    && cpu_addr == first_index_register + {8'h00, $past(cpu_data_in, 2)}
    && cpu_data_out == store_data[7:0]) ##1 instr_done)
    else $error("Byte store cycles wrong");
  AST_LOAD_Y_X: assert property (
    fetch && cpu_data_in == 8'h1a ##1 cpu_data_in == 8'hee |=> ##1
    cpu_addr == 16'hffff ##1 (cpu_read && cpu_addr == first_index_register
    + {8'h00, $past(cpu_data_in, 2)}) ##1 (cpu_read
    && cpu_addr == $past(cpu_addr) + 16'h1) ##1 instr_done)
    else $error("Second index load cycles wrong");
  AST_STORE_Y_X: assert property (
    fetch && cpu_data_in == 8'h1a ##1 cpu_data_in == 8'hef |=> ##2
    (!cpu_read && cpu_data_out == store_data[15:8]) ##1 (!cpu_read
    && cpu_data_out == store_data[7:0] && cpu_addr == $past(cpu_addr) + 16'h1))
    else $error("Second index store cycles wrong");
  AST_CMP_EXT: assert property (
    fetch && cpu_data_in == 8'h1a ##1 (cpu_data_in == 8'hb3
    || cpu_data_in == 8'hbc) |=> ##2 (cpu_read
    && cpu_addr == {$past(cpu_data_in, 2), $past(cpu_data_in)})
    ##1 (cpu_addr == $past(cpu_addr) + 16'h1)
    ##1 (cpu_read && cpu_addr == 16'hffff) ##1 instr_done)
    else $error("Extended compare cycles wrong");
  AST_READ8_EXT: assert property (
    fetch && cpu_data_in[7:4] == 4'hb && cpu_data_in != 8'hbd |-> ##3
    (cpu_read && cpu_addr == {$past(cpu_data_in, 2), $past(cpu_data_in)})
    ##1 instr_done)
    else $error("Extended byte read cycles wrong");
endmodule

bind cbs_seq cbs_seq_sva #(.START_PC(START_PC)) cbs_seq_sva_i (
  .clk_sys, .sys_rst, .cpu_addr, .cpu_read, .cpu_data_in, .cpu_data_out,
  .cpu_data_oe, .first_index_register, .stack_ptr, .store_data,
  .operand_data, .opcode, .instr_done);

// [test/cbs_seq_tb.sv]
// Self-checking bench for the bus-cycle sequencer
`timescale 1ns/1ps
module cbs_seq_tb;
  typedef struct {
    logic [31:0] b;
    int          len;
    logic        ext;
    int          n;
    logic [55:0] c;
  } cbs_row_t;
  localparam logic [15:0] START = 16'h0000;
  localparam logic [15:0] XREG  = 16'h4000;
  localparam logic [15:0] SPV   = 16'h0100;
  localparam int          NROW  = 16;
  localparam logic [15:0] CSEQ [7] = '{16'h4080, 16'h4081, 16'h4082,
    16'h5000, SPV, SPV - 16'h1, 16'h5001};
  // Cycle code: write, high data byte, kind (pc ffff ea sp), step
  cbs_row_t rows [NROW] = '{
    '{32'h01000000, 1, 1'b0, 1, 56'h00000000000000},
    '{32'ha6020000, 2, 1'b0, 4, 56'h00011020000000},
    '{32'ha7030000, 2, 1'b0, 4, 56'h000110a0000000},
    '{32'he70b0000, 2, 1'b0, 4, 56'h000110a0000000},
    '{32'ha3040000, 2, 1'b0, 6, 56'h00011020211000},
    '{32'hac0d0000, 2, 1'b0, 6, 56'h00011020211000},
    '{32'hec050000, 2, 1'b0, 5, 56'h00011020210000},
    '{32'hae0c0000, 2, 1'b0, 5, 56'h00011020210000},
    '{32'hed060000, 2, 1'b0, 5, 56'h000110e0a10000},
    '{32'h60070000, 2, 1'b0, 6, 56'h0001102010a000},
    '{32'h6d080000, 2, 1'b0, 6, 56'h00011020101000},
    '{32'h1aee0900, 3, 1'b0, 6, 56'h00010210202100},
    '{32'h1aef0a00, 3, 1'b0, 6, 56'h00010210e0a100},
    '{32'h1ab32345, 4, 1'b1, 7, 56'h00010203202110},
    '{32'hb6345600, 3, 1'b1, 4, 56'h00010220000000},
    '{32'h6e800000, 2, 1'b0, 3, 56'h00011000000000}
  };
  logic        clk_sys;
  logic        sys_rst;
  logic [15:0] cpu_addr;
  logic        cpu_read;
  logic [7:0]  cpu_data_in;
  logic [7:0]  cpu_data_out;
  logic        cpu_data_oe;
  logic [15:0] first_index_register;
  logic [15:0] stack_ptr;
  logic [15:0] store_data;
  logic [15:0] operand_data;
  logic [7:0]  opcode;
  logic        instr_done;
  logic [15:0] pc;
  logic [15:0] ea;
  logic [15:0] ex;
  logic [15:0] sd;
  logic [7:0]  cc;
  logic [7:0]  lastop;
  logic [7:0]  wd;
  int          row_n;
  int          fail_count = 0;
  int          n_tests = 0;

  cbs_seq #(.START_PC(START)) cbs_seq_i (
    .clk_sys, .sys_rst, .cpu_addr, .cpu_read, .cpu_data_in, .cpu_data_out,
    .cpu_data_oe, .first_index_register, .stack_ptr, .store_data,
    .operand_data, .opcode, .instr_done);
  cbs_mem_model cbs_mem_model_i (
    .clk_sys, .cpu_addr, .cpu_read, .cpu_data_out, .cpu_data_oe,
    .cpu_data_in);

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_idle();
    chk("idle address", START, cpu_addr);
    chk("idle read", 16'h0001, 16'(cpu_read));
    chk("idle enable", 16'h0000, 16'(cpu_data_oe));
    chk("idle done", 16'h0000, 16'(instr_done));
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Varies per row so a byte swap or stale value shows
  always @(posedge clk_sys) begin
    store_data <= 16'ha5c0 ^ 16'(row_n);
  end

  initial begin
    repeat (2000) @(posedge clk_sys);
    fail_count++;
    $display("Error watchdog expected finish seen timeout");
    tally_and_finish();
  end

  initial begin
    sys_rst <= 1'b1;
    first_index_register <= XREG;
    stack_ptr <= SPV;
    row_n = 0;
    pc = START;
    @(posedge clk_sys);
    for (int r = 0; r < NROW; r++) begin
      for (int i = 0; i < rows[r].len; i++) begin
        cbs_mem_model_i.mem[pc + 16'(i)] = rows[r].b[31 - 8 * i -: 8];
      end
      pc = pc + 16'(rows[r].len);
    end
    cbs_mem_model_i.mem[16'h4080] = 8'hbd;
    cbs_mem_model_i.mem[16'h4081] = 8'h50;
    cbs_mem_model_i.mem[16'h4082] = 8'h00;
    cbs_mem_model_i.mem[16'h5001] = 8'h1a;
    cbs_mem_model_i.mem[16'h5002] = 8'hef;
    cbs_mem_model_i.mem[16'h5003] = 8'h01;
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    chk_idle();
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    pc = START;
    for (int r = 0; r < NROW; r++) begin
      row_n = r;
      ea = rows[r].ext ? rows[r].b[47 - 8 * rows[r].len -: 16]
                       : XREG + {8'h00, rows[r].b[39 - 8 * rows[r].len -: 8]};
      sd = 16'ha5c0 ^ 16'(r);
      for (int k = 0; k < rows[r].n; k++) begin
        @(negedge clk_sys);
        cc = rows[r].c[55 - 8 * k -: 8];
        case (cc[5:4])
          2'h0: ex = pc + {12'h000, cc[3:0]};
          2'h1: ex = 16'hffff;
          2'h2: ex = ea + {12'h000, cc[3:0]};
          default: ex = SPV - {12'h000, cc[3:0]};
        endcase
        chk("address", ex, cpu_addr);
        chk("read line", 16'(!cc[7]), 16'(cpu_read));
        chk("done", 16'(k == 0 && r > 0), 16'(instr_done));
        wd = cc[6] ? sd[15:8] : sd[7:0];
        if (cc[7]) chk("wdata", 16'(wd), 16'(cpu_data_out));
        if (k == 0 && r > 0) begin
          chk("opcode", 16'(lastop), 16'(opcode));
        end
      end
      lastop = (rows[r].b[31:24] == 8'h1a) ? rows[r].b[23:16]
                                           : rows[r].b[31:24];
      pc = (r == NROW - 1) ? ea : pc + 16'(rows[r].len);
    end
    // Call reached through the jump, then a store whose low byte still goes out after reset is raised
    row_n = NROW;
    for (int k = 0; k < 7; k++) begin
      @(negedge clk_sys);
      chk("call address", CSEQ[k], cpu_addr);
      chk("call read", 16'(k < 4 || k == 6), 16'(cpu_read));
      if (k == 0) begin
        // Compare high byte at 2345, then the extended byte read at 3456
        chk("operand", 16'h6662, operand_data);
      end
      if (k == 4 || k == 5) begin
        chk("return byte", k == 4 ? 16'h0083 : 16'h0040,
            16'(cpu_data_out));
      end
    end
    chk("call done", 16'h0001, 16'(instr_done));
    for (int k = 0; k < 8 && cpu_read === 1'b1; k++) begin
      @(negedge clk_sys);
    end
    chk("store address", 16'h4001, cpu_addr);
    @(posedge clk_sys);
    sys_rst <= 1'b1;
    @(negedge clk_sys);
    chk("store low", 16'h00d0, 16'(cpu_data_out));
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk_idle();
    @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(negedge clk_sys);
    chk_idle();
    tally_and_finish();
  end
endmodule
